/* File: src/sadc_port.sv */
/*
  Serial control and result port of an eight-input successive-approximation converter,
  with an AXI4-Lite register side on aclk. The input voltages are modelled by registers
  holding a 13-bit level in units of reference/4096.
  Assumes the host keeps the serial clock still while select is high and gives sixteen
  falling edges per frame; aresetn reaches the link logic only while the serial clock runs.
*/
`timescale 1ns/1ps
module sadc_port
  import sadc_pkg::*;
(
  // register side
  input  wire logic          aclk,
  input  wire logic          aresetn,
  input  wire sadc_axi_req_t axi_req,
  output sadc_axi_rsp_t      axi_rsp,
  // serial link
  input  wire logic          sclk,
  input  wire logic          cs_n,
  input  wire logic          din,
  output logic               dout,
  output logic               dout_oe,
  // converter front end
  output logic [CH_W-1:0]    mux_chan,
  output logic               tracking
);

  typedef struct packed {
    sadc_cfg_t           cfg;
    logic [CH_W-1:0]     chan;
    logic [CH_W-1:0]     conv_ch;
    logic                track;
    logic [STAT_W-1:0]   stat;
    logic                tgl;
  } sadc_lnk_t;
  localparam sadc_lnk_t LNK_RST = sadc_lnk_t'({CFG_RST, 3'h0, 3'h0, 1'h1, 26'h0, 1'h0});

  typedef struct packed {
    logic                    aw_full;
    logic [AXI_AW-1:0]       awaddr;
    logic                    w_full;
    logic [AXI_DW-1:0]       wdata;
    logic [3:0]              wstrb;
    sadc_axi_rsp_t           rsp;
    logic [NCH-1:0][VIN_W-1:0] vin;
    logic                    commit;
    logic                    tgl_seen;
    logic [STAT_W-1:0]       stat;
    logic [15:0]             frames;
  } sadc_bus_t;

  sadc_frm_t                 f_q, f_d;
  sadc_lnk_t                 l_q, l_d;
  sadc_bus_t                 b_q, b_d;
  logic                      sclk_fall;
  logic                      lrst_n;
  logic                      tgl_s;
  logic                      busy;
  logic [NCH-1:0][VIN_W-1:0] vin_l;
  logic [4:0]                edge_no;
  logic [3:0]                bit_idx;
  logic [RES_W-1:0]          trial;
  logic                      keep;
  logic [VIN_W-1:0]          vin_sel;
  logic [RES_W-1:0]          scaled;
  logic [CH_W-1:0]           next_ch;
  logic [RES_W-1:0]          res_code;

  // ----------------------------------------------------------------------------
  // crossings
  // ----------------------------------------------------------------------------
  // link logic acts on falling serial edges, so it is clocked by the inverted pin
  assign sclk_fall = ~sclk;

  sadc_sync #(.W(1)) u_lrst (.clk(sclk_fall), .d(aresetn), .q(lrst_n));
  sadc_sync #(.W(1)) u_done (.clk(aclk), .d(l_q.tgl), .q(tgl_s));

  sadc_xfer #(.W(NCH*VIN_W)) u_vin (
    .src_clk   (aclk),
    .src_rst_n (aresetn),
    .src_valid (b_q.commit),
    .src_data  (b_q.vin),
    .src_busy  (busy),
    .dst_clk   (sclk_fall),
    .dst_rst_n (lrst_n),
    .dst_data  (vin_l)
  );

  // ----------------------------------------------------------------------------
  // frame datapath
  // ----------------------------------------------------------------------------
  assign edge_no = 5'(f_q.cnt + 5'h01);
  assign bit_idx = 4'(EDGE_LAST - edge_no);
  assign trial   = f_q.sar | (12'h001 << bit_idx);
  assign keep    = f_q.held >= trial;
  assign vin_sel = vin_l[l_q.chan];
  assign scaled  = (l_q.cfg.span_sel == SPAN_REF) ?
                   (vin_sel[VIN_W-1] ? 12'hFFF : vin_sel[RES_W-1:0]) : vin_sel[VIN_W-1:1];
  assign res_code = {f_d.sar[RES_W-1] ^ (l_q.cfg.code_sel != CODING_BIN),
                     f_d.sar[RES_W-2:0]};

  always_comb begin
    f_d      = f_q;
    f_d.oe   = 1'b1;
    f_d.dout = 1'b0;
    if (f_q.cnt < EDGE_LAST) begin
      f_d.cnt = edge_no;
    end
    if (edge_no <= EDGE_CFG_LAST) begin
      f_d.shin = {f_q.shin[RES_W-2:0], din};
    end
    if (edge_no == EDGE_SAMPLE) begin
      f_d.held = scaled;
      f_d.sar  = 12'h000;
    end
    if (edge_no == EDGE_ID_HI) begin
      f_d.dout = l_q.chan[1];
    end
    if (edge_no == EDGE_ID_LO) begin
      f_d.dout = l_q.chan[0];
    end
    if ((edge_no >= EDGE_DATA) && (edge_no <= EDGE_LAST)) begin
      // one approximation step per falling edge, result bit leaves at once
      f_d.sar  = keep ? trial : f_q.sar;
      f_d.dout = keep ^ ((edge_no == EDGE_DATA) && (l_q.cfg.code_sel != CODING_BIN));
    end
  end

  // select high clears the frame and releases the pin before any serial edge
  always_ff @(posedge sclk_fall or posedge cs_n) begin
    if (cs_n) begin
      f_q <= FRM_RST;
    end else begin
      f_q <= f_d;
    end
  end

  // ----------------------------------------------------------------------------
  // configuration, sequencer and tracking
  // ----------------------------------------------------------------------------
  always_comb begin
    next_ch = l_q.cfg.channel_address;
    // the shadow register contents are not modelled: sequence runs 0 up to the address
    if (l_q.cfg.sequence_enable) begin
      next_ch = (l_q.chan >= l_q.cfg.channel_address) ? 3'h0 : 3'(l_q.chan + 3'h1);
    end
  end

  always_comb begin
    l_d = l_q;
    if ((edge_no == EDGE_CFG_LAST) && f_q.shin[CFG_W-1]) begin
      l_d.cfg = sadc_cfg_t'({f_q.shin[CFG_W-2:0], din});
    end
    if (edge_no == EDGE_SAMPLE) begin
      l_d.conv_ch = l_q.chan;
      l_d.track   = 1'b0;
    end
    if (edge_no == EDGE_MUX) begin
      l_d.chan = next_ch;
    end
    if (edge_no == EDGE_LAST) begin
      l_d.track = 1'b1;
      l_d.stat  = {l_q.cfg, l_q.conv_ch, res_code};
      l_d.tgl   = ~l_q.tgl;
    end
  end

  always_ff @(posedge sclk_fall) begin
    if (!lrst_n) begin
      l_q <= LNK_RST;
    end else begin
      l_q <= l_d;
    end
  end

  // ----------------------------------------------------------------------------
  // register slave
  // ----------------------------------------------------------------------------
  always_comb begin
    b_d        = b_q;
    b_d.commit = 1'b0;
    if (axi_req.awvalid && b_q.rsp.awready) begin
      b_d.aw_full = 1'b1;
      b_d.awaddr  = axi_req.awaddr;
    end
    if (axi_req.wvalid && b_q.rsp.wready) begin
      b_d.w_full = 1'b1;
      b_d.wdata  = axi_req.wdata;
      b_d.wstrb  = axi_req.wstrb;
    end
    if (b_q.aw_full && b_q.w_full && !b_q.rsp.bvalid) begin
      b_d.aw_full   = 1'b0;
      b_d.w_full    = 1'b0;
      b_d.rsp.bvalid = 1'b1;
      b_d.rsp.bresp  = RESP_OKAY;
      if (b_q.awaddr == OFS_CTRL) begin
        b_d.commit = b_q.wdata[CTRL_COMMIT_BIT] & b_q.wstrb[0];
      end else if ((b_q.awaddr[7:5] == OFS_VIN0[7:5]) && (b_q.awaddr[1:0] == 2'h0)) begin
        if (b_q.wstrb[0]) begin
          b_d.vin[b_q.awaddr[4:2]][7:0] = b_q.wdata[7:0];
        end
        if (b_q.wstrb[1]) begin
          b_d.vin[b_q.awaddr[4:2]][VIN_W-1:8] = b_q.wdata[VIN_W-1:8];
        end
      end else if ((b_q.awaddr != OFS_STATUS) && (b_q.awaddr != OFS_CONFIG) &&
                   (b_q.awaddr != OFS_RESULT)) begin
        b_d.rsp.bresp = RESP_SLVERR;
      end
    end
    if (axi_req.bready && b_q.rsp.bvalid) begin
      b_d.rsp.bvalid = 1'b0;
    end
    if (axi_req.arvalid && b_q.rsp.arready) begin
      b_d.rsp.rvalid = 1'b1;
      b_d.rsp.rresp  = RESP_OKAY;
      b_d.rsp.rdata  = 32'h0000_0000;
      if (axi_req.araddr == OFS_CTRL) begin
        b_d.rsp.rdata = 32'h0000_0000;
      end else if (axi_req.araddr == OFS_STATUS) begin
        b_d.rsp.rdata[STAT_BUSY_BIT] = busy;
        b_d.rsp.rdata[STAT_FRAMES_LSB +: 16] = b_q.frames;
      end else if (axi_req.araddr == OFS_CONFIG) begin
        b_d.rsp.rdata[CFG_W-1:0] = b_q.stat[STAT_W-1 -: CFG_W];
      end else if (axi_req.araddr == OFS_RESULT) begin
        b_d.rsp.rdata[RESULT_CH_LSB +: CH_W] = b_q.stat[RES_W +: CH_W];
        b_d.rsp.rdata[RES_W-1:0]             = b_q.stat[RES_W-1:0];
      end else if ((axi_req.araddr[7:5] == OFS_VIN0[7:5]) && (axi_req.araddr[1:0] == 2'h0)) begin
        b_d.rsp.rdata[VIN_W-1:0] = b_q.vin[axi_req.araddr[4:2]];
      end else begin
        b_d.rsp.rresp = RESP_SLVERR;
      end
    end
    if (axi_req.rready && b_q.rsp.rvalid) begin
      b_d.rsp.rvalid = 1'b0;
    end
    // stat is held steady for a whole frame after each toggle, so it can be copied
    if (tgl_s != b_q.tgl_seen) begin
      b_d.tgl_seen = tgl_s;
      b_d.stat     = l_q.stat;
      b_d.frames   = 16'(b_q.frames + 16'h0001);
    end
    b_d.rsp.awready = !b_d.aw_full;
    b_d.rsp.wready  = !b_d.w_full;
    b_d.rsp.arready = !b_d.rsp.rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      b_q <= '0;
    end else begin
      b_q <= b_d;
    end
  end

  assign axi_rsp  = b_q.rsp;
  assign dout     = f_q.dout;
  assign dout_oe  = f_q.oe;
  assign mux_chan = l_q.chan;
  assign tracking = l_q.track;

  // ----------------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------------
  property p_cfg_gate;
    @(posedge sclk_fall) disable iff (cs_n || !lrst_n || !aresetn)
    (f_q.cnt == 5'h0B) |=> (l_q.cfg == ($past(f_q.shin[CFG_W-1]) ?
      sadc_cfg_t'({$past(f_q.shin[CFG_W-2:0]), $past(din)}) : $past(l_q.cfg)));
  endproperty
  a_cfg_gate: assert property (p_cfg_gate) else $error("config load gate wrong");

  property p_cfg_window;
    @(posedge sclk_fall) disable iff (cs_n || !lrst_n || !aresetn)
    $changed(l_q.cfg) |-> (f_q.cnt == EDGE_CFG_LAST);
  endproperty
  a_cfg_window: assert property (p_cfg_window) else $error("config changed late");

  property p_mux_edge;
    @(posedge sclk_fall) disable iff (cs_n || !lrst_n || !aresetn)
    $changed(l_q.chan) |-> (f_q.cnt == EDGE_MUX);
  endproperty
  a_mux_edge: assert property (p_mux_edge) else $error("mux moved off edge 14");

  property p_lead_id;
    @(posedge sclk_fall) disable iff (cs_n || !lrst_n || !aresetn)
    (f_q.cnt == EDGE_ID_HI) |-> (f_q.dout == l_q.chan[1]) ##1 (f_q.dout == l_q.chan[0]);
  endproperty
  a_lead_id: assert property (p_lead_id) else $error("channel id bits wrong");

  property p_lead_zero;
    @(posedge sclk_fall) disable iff (cs_n || !lrst_n || !aresetn)
    (f_q.cnt == EDGE_SAMPLE) |-> !f_q.dout ##1 !f_q.dout;
  endproperty
  a_lead_zero: assert property (p_lead_zero) else $error("leading zeros missing");

  property p_convert;
    @(posedge sclk) disable iff (cs_n || !lrst_n || !aresetn)
    (f_q.cnt == EDGE_SAMPLE) |-> ##15 (f_q.sar == f_q.held);
  endproperty
  a_convert: assert property (p_convert) else $error("conversion result wrong");

  property p_span;
    @(posedge sclk_fall) disable iff (cs_n || !lrst_n || !aresetn)
    (f_q.cnt == EDGE_SAMPLE) |-> (f_q.held == $past(scaled));
  endproperty
  a_span: assert property (p_span) else $error("sampled span wrong");

  property p_msb_code;
    @(posedge sclk_fall) disable iff (cs_n || !lrst_n || !aresetn)
    (f_q.cnt == EDGE_DATA) |->
      (f_q.dout == (f_q.sar[RES_W-1] ^ (l_q.cfg.code_sel != CODING_BIN)));
  endproperty
  a_msb_code: assert property (p_msb_code) else $error("msb coding wrong");

  property p_track;
    @(posedge sclk) disable iff (cs_n || !lrst_n || !aresetn)
    (f_q.cnt == EDGE_SAMPLE) |-> !l_q.track [*8] ##8 l_q.track;
  endproperty
  a_track: assert property (p_track) else $error("tracking not resumed");

  property p_hiz;
    @(posedge aclk) disable iff (!aresetn)
    cs_n |-> !dout_oe;
  endproperty
  a_hiz: assert property (p_hiz) else $error("output driven outside frame");

  property p_rhold;
    @(posedge aclk) disable iff (!aresetn)
    (axi_rsp.rvalid && !axi_req.rready) |=> (axi_rsp.rvalid && $stable(axi_rsp.rdata));
  endproperty
  a_rhold: assert property (p_rhold) else $error("read data dropped");

  c_frame: cover property (@(posedge sclk) disable iff (cs_n) f_q.cnt == EDGE_LAST);
  c_cfgwr: cover property (@(posedge sclk_fall) disable iff (cs_n) $changed(l_q.cfg));
  c_wrap:  cover property (@(posedge sclk_fall) disable iff (cs_n)
                           l_q.cfg.sequence_enable && $changed(l_q.chan) && l_q.chan == 3'h0);
  c_bwr:   cover property (@(posedge aclk) disable iff (!aresetn)
                           axi_rsp.bvalid && axi_req.bready);

endmodule : sadc_port

/* File: src/sadc_pkg.sv */
/*
  Shared constants and types for the sequenced converter serial port: frame edge numbers,
  register offsets and field positions, configuration layout and the AXI4-Lite carriers.
  Assumes a 50 MHz aclk for the register side and a host-driven serial clock for the link.
*/
// Summary of operation
// - serial clock shifts data and alone steps the conversion.
// - configuration input bits are captured on serial clock falling edges.
// - frame select low bounds the frame and starts sampling and conversion.
// - channel address bits pick one of eight inputs for conversion.
// - channel address with sequence and shadow bits programs automatic channel sequencing; code ignores shadow_sel and runs 0 up to the address.
// - span bit selects zero to reference or zero to twice reference.
// - each result bit leaves on a falling serial clock edge.
// - frame sends two zeros, channel id bits, then twelve result bits msb first.
// - coding bit selects straight binary or two's complement results.
// - sampling stage returns to tracking when each conversion ends.
// - every transfer spans sixteen serial clocks, writing and reading together.
// - only the first twelve falling edges load configuration bits.
// - leading write bit one loads eleven bits, zero leaves configuration unchanged.
// - multiplexer switches to the next channel on the fourteenth falling edge.
package sadc_pkg;

  // --------------------------------------------------------------------------
  // widths
  // --------------------------------------------------------------------------
  localparam int unsigned AXI_AW = 8;
  localparam int unsigned AXI_DW = 32;
  localparam int unsigned RES_W  = 12;
  localparam int unsigned VIN_W  = 13;
  localparam int unsigned NCH    = 8;
  localparam int unsigned CH_W   = 3;
  localparam int unsigned CNT_W  = 5;
  localparam int unsigned CFG_W  = 11;
  localparam int unsigned STAT_W = CFG_W + CH_W + RES_W;

  // --------------------------------------------------------------------------
  // frame edge numbers, counted from the first falling edge after select
  // --------------------------------------------------------------------------
  localparam logic [4:0] EDGE_SAMPLE   = 5'h01;
  localparam logic [4:0] EDGE_ID_HI    = 5'h03;
  localparam logic [4:0] EDGE_ID_LO    = 5'h04;
  localparam logic [4:0] EDGE_DATA     = 5'h05;
  localparam logic [4:0] EDGE_CFG_LAST = 5'h0C;
  localparam logic [4:0] EDGE_MUX      = 5'h0E;
  localparam logic [4:0] EDGE_LAST     = 5'h10;

  // --------------------------------------------------------------------------
  // register map and fields
  // --------------------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_CONFIG = 8'h08;
  localparam logic [7:0] OFS_RESULT = 8'h0C;
  localparam logic [7:0] OFS_VIN0   = 8'h20;
  localparam int unsigned CTRL_COMMIT_BIT = 0;
  localparam int unsigned STAT_BUSY_BIT   = 0;
  localparam int unsigned STAT_FRAMES_LSB = 16;
  localparam int unsigned RESULT_CH_LSB   = 12;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic       SPAN_REF    = 1'h1;
  localparam logic       CODING_BIN  = 1'h1;

  // --------------------------------------------------------------------------
  // types
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic       sequence_enable;
    logic       spare_hi;
    logic [2:0] channel_address;
    logic [1:0] power_mode;
    logic       shadow_sel;
    logic       spare_lo;
    logic       span_sel;
    logic       code_sel;
  } sadc_cfg_t;
  localparam sadc_cfg_t CFG_RST = sadc_cfg_t'(11'h000);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic [RES_W-1:0] shin;
    logic [RES_W-1:0] held;
    logic [RES_W-1:0] sar;
    logic             dout;
    logic             oe;
  } sadc_frm_t;
  localparam sadc_frm_t FRM_RST = sadc_frm_t'(43'h0);

  typedef struct packed {
    logic        awvalid;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [7:0]  araddr;
    logic        rready;
  } sadc_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } sadc_axi_rsp_t;

endpackage : sadc_pkg

/* File: src/sadc_sync.sv */
/*
  Two-flop level synchroniser, any width.
  Assumes each bit is a level or is held stable around its change by the sender.
*/
`timescale 1ns/1ps
module sadc_sync #(
  parameter int unsigned W = 1
) (
  // clock
  input  wire logic         clk,
  // level in and out
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s2;
    logic [W-1:0] s1;
  } sadc_sync_t;
  sadc_sync_t st_q, st_d;

  always_comb begin
    st_d    = st_q;
    st_d.s1 = d;
    st_d.s2 = st_q.s1;
  end

  always_ff @(posedge clk) begin
    st_q <= st_d;
  end

  assign q = st_q.s2;
endmodule : sadc_sync

/* File: src/sadc_xfer.sv */
/*
  Toggle handshake carrying one word from a source domain to a destination domain.
  Assumes the source offers a new word only while busy is low; the held word stays
  put until the destination has acknowledged it.
*/
`timescale 1ns/1ps
module sadc_xfer #(
  parameter int unsigned W = 8
) (
  // source side
  input  wire logic         src_clk,
  input  wire logic         src_rst_n,
  input  wire logic         src_valid,
  input  wire logic [W-1:0] src_data,
  output logic              src_busy,
  // destination side
  input  wire logic         dst_clk,
  input  wire logic         dst_rst_n,
  output logic      [W-1:0] dst_data
);
  typedef struct packed {
    logic [W-1:0] hold;
    logic         req;
    logic         busy;
  } sadc_src_t;
  typedef struct packed {
    logic [W-1:0] data;
    logic         seen;
  } sadc_dst_t;
  sadc_src_t s_q, s_d;
  sadc_dst_t d_q, d_d;
  logic      ack_s;
  logic      req_s;

  sadc_sync #(.W(1)) u_ack (.clk(src_clk), .d(d_q.seen), .q(ack_s));
  sadc_sync #(.W(1)) u_req (.clk(dst_clk), .d(s_q.req), .q(req_s));

  // ----------------------------------------------------------------------------
  // source domain
  // ----------------------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    if (s_q.busy && (ack_s == s_q.req)) begin
      s_d.busy = 1'b0;
    end else if (!s_q.busy && src_valid) begin
      s_d.hold = src_data;
      s_d.req  = ~s_q.req;
      s_d.busy = 1'b1;
    end
  end

  always_ff @(posedge src_clk) begin
    if (!src_rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------------------
  // destination domain: hold is stable while the request toggle is in flight
  // ----------------------------------------------------------------------------
  always_comb begin
    d_d = d_q;
    if (req_s != d_q.seen) begin
      d_d.data = s_q.hold;
      d_d.seen = req_s;
    end
  end

  always_ff @(posedge dst_clk) begin
    if (!dst_rst_n) begin
      d_q <= '0;
    end else begin
      d_q <= d_d;
    end
  end

  assign src_busy = s_q.busy;
  assign dst_data = d_q.data;
endmodule : sadc_xfer

/* File: bench/sadc_host.sv */
/*
  Host model: frames the link, shifts a config word in and the result word out.
  Assumes a 160 ns serial clock that stands high while select is high.
*/
`timescale 1ns/1ps
module sadc_host (
  // link pins
  output logic      sclk,
  output logic      cs_n,
  output logic      din,
  input  wire logic line
);
  initial begin
    sclk = 1'b1;
    cs_n = 1'b1;
    din  = 1'b0;
  end

  // --------------------------------------------------------------------------
  // one frame of sixteen falling edges
  // --------------------------------------------------------------------------
  task automatic frame(input logic [11:0] cfg, output logic [15:0] got);
    got = 16'h0;
    cs_n <= 1'b0;
    din  <= cfg[11];
    #37;
    for (int i = 0; i < 16; i++) begin
      sclk <= 1'b0;
      #80;
      sclk <= 1'b1;
      got = {got[14:0], line};
      // bits past the twelfth toggle so a stray load shows up
      din <= (i < 11) ? cfg[10-i] : ~din;
      #80;
    end
    cs_n <= 1'b1;
    din  <= ~din;
    // quiet gap: back-to-back frames still see select high, and idle pins settle
    #80;
  endtask : frame
endmodule : sadc_host

/* File: bench/sadc_port_test.sv */
/*
  Self-checking bench for the converter serial port.
  Assumes the host model in sadc_host and the hand-over timing of the port.
*/
`timescale 1ns/1ps
module sadc_port_test;
  import sadc_pkg::*;
  logic            aclk = 1'b0;
  logic            aresetn = 1'b0;
  sadc_axi_req_t   req;
  sadc_axi_rsp_t   rsp;
  logic            sclk, cs_n, din, dout, dout_oe, tracking;
  logic [CH_W-1:0] mux_chan;
  wire             line;
  int              miscompares = 0;
  int              checks_done = 0;
  logic [15:0]     got;
  logic [31:0]     rd_d;
  logic [1:0]      rd_r;

  assign line = dout_oe ? dout : 1'bz;
  always #10 aclk = ~aclk;

  sadc_port sadc_port_i (.aclk(aclk), .aresetn(aresetn), .axi_req(req), .axi_rsp(rsp),
    .sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout), .dout_oe(dout_oe),
    .mux_chan(mux_chan), .tracking(tracking));
  sadc_host sadc_host_i (.sclk(sclk), .cs_n(cs_n), .din(din), .line(line));

  // --------------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : close_out

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge aclk);
    req.awvalid <= 1'b1;
    req.awaddr  <= a;
    req.wvalid  <= 1'b1;
    req.wdata   <= d;
    req.wstrb   <= 4'hF;
    while (!rsp.bvalid && n < 100) begin
      @(posedge aclk);
      n++;
      if (rsp.awready) req.awvalid <= 1'b0;
      if (rsp.wready) req.wvalid <= 1'b0;
    end
    chk("bvalid", 32'(rsp.bvalid), 32'h1);
    chk("bresp", 32'(rsp.bresp), 32'(RESP_OKAY));
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n = 0;
    @(posedge aclk);
    req.arvalid <= 1'b1;
    req.araddr  <= a;
    // rready waits for rvalid so the slave has to hold its answer one cycle
    req.rready  <= 1'b0;
    do begin
      @(posedge aclk);
      n++;
      if (rsp.arready) req.arvalid <= 1'b0;
      if (rsp.rvalid) req.rready <= 1'b1;
    end while (!(rsp.rvalid && req.rready) && n < 100);
    chk("rvalid", 32'(rsp.rvalid), 32'h1);
    d = rsp.rdata;
    r = rsp.rresp;
  endtask : rd

  task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    rd(a, rd_d, rd_r);
    chk(what, rd_d, exp);
  endtask : rchk

  // --------------------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------------------
  task automatic t_reset_map;
    rchk("config at reset", OFS_CONFIG, 32'h0);
    rd(8'h10, rd_d, rd_r);
    chk("unmapped resp", 32'(rd_r), 32'(RESP_SLVERR));
  endtask : t_reset_map

  task automatic t_route_span;
    int n = 0;
    wr(OFS_VIN0, 32'h123);
    wr(OFS_VIN0 + 8'h14, 32'hABC);
    wr(OFS_CTRL, 32'h1);
    // the commit needs serial edges to land, so the first frame carries it
    sadc_host_i.frame(12'h943, got);
    chk("mux after write", 32'(mux_chan), 32'h5);
    chk("tracking idle", 32'(tracking), 32'h1);
    chk("dout_oe idle", 32'(dout_oe), 32'h0);
    do begin
      rd(OFS_STATUS, rd_d, rd_r);
      n++;
    end while (rd_d[0] !== 1'b0 && n < 20);
    chk("commit busy", 32'(rd_d[0]), 32'h0);
    sadc_host_i.frame(12'h000, got);
    chk("frame ch5 span ref", 32'(got), 32'h1ABC);
    repeat (10) @(posedge aclk);
    rchk("config", OFS_CONFIG, 32'h143);
    rchk("result", OFS_RESULT, 32'h5ABC);
  endtask : t_route_span

  task automatic t_gate_coding;
    sadc_host_i.frame(12'h800, got);
    chk("mux back to 0", 32'(mux_chan), 32'h0);
    sadc_host_i.frame(12'h7FF, got);
    chk("frame ch0 twos", 32'(got), 32'h0891);
    repeat (10) @(posedge aclk);
    rchk("config kept", OFS_CONFIG, 32'h0);
  endtask : t_gate_coding

  task automatic t_sequence;
    sadc_host_i.frame(12'hC43, got);
    chk("frame ch0 before seq", 32'(got), 32'h0891);
    chk("seq step", 32'(mux_chan), 32'h1);
    sadc_host_i.frame(12'h000, got);
    chk("frame ch1 seq", 32'(got), 32'h1000);
    chk("seq wrap", 32'(mux_chan), 32'h0);
    repeat (10) @(posedge aclk);
    rchk("frames done", OFS_STATUS, 32'h0006_0000);
  endtask : t_sequence

  initial begin
    req = '0;
    req.bready = 1'b1;
    req.rready = 1'b1;
    repeat (12) @(posedge aclk);
    // link reset only passes while the serial clock runs
    sadc_host_i.frame(12'h000, got);
    @(posedge aclk);
    aresetn <= 1'b1;
    t_reset_map();
    t_route_span();
    t_gate_coding();
    t_sequence();
    close_out();
  end

  initial begin
    #300000;
    miscompares++;
    close_out();
  end
endmodule : sadc_port_test
